// >>> logic/uhtss_top.sv
/*
 * Host token launcher and frame scheduler with a classic Wishbone slave.
 * Assumes a serial engine on the same clock that takes a launch pulse
 * and answers with a done pulse, flagged when the peripheral NAKed.
 */
// Chosen here: the Wishbone register port.
// Behaviour
// - Tokens launch only with host operation enabled
// - Token write starts transaction to held address
// - Transfer follows endpoint-zero handshake and retry
// - Bits 7:4 hold the target endpoint
// - Bits 3:0 select the token type
// - Frame counter reloads 12000 for 1 ms
// - Counter reaching zero sends start-of-frame token
// - Past threshold, no tokens until next frame
// - Threshold is eight bits in byte times
// - Threshold acts only in host operation
// - Mid page gives base bits 23:16
// - High page gives base bits 31:24
// - Host enable is control bit 3
// - Base aligned to 512, low page 15:9
// - Low-speed bit makes next token slow, preambled unless endpoint-zero no-hub bit 7 set
module uhtss_top (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [31:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Token request to the serial engine
    output logic tok_launch_out,
    output logic [3:0] tok_pid_out,
    output logic [3:0] tok_endpoint_out,
    output logic [6:0] tok_addr_out,
    output logic tok_low_speed_out,
    output logic tok_preamble_out,
    output logic tok_handshake_out,
    output logic tok_retry_dis_out,
    // Answer from the serial engine
    input wire logic link_done_in,
    input wire logic link_nak_in,
    // Frame and descriptor table
    output logic sof_send_out,
    output logic [31:0] descriptor_base_out
);

    function automatic logic reg_hit(input logic [31:0] a, input logic [23:0] off);
        return a[23:2] == off[23:2];
    endfunction : reg_hit
    function automatic logic pid_valid(input logic [3:0] p);
        return p == uhtss_pkg::PID_OUT || p == uhtss_pkg::PID_IN || p == uhtss_pkg::PID_SETUP;
    endfunction : pid_valid

    // Reset release
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    logic nrst;
    assign nrst = rst_sync_q;

    // Registers
    logic [7:0] control_q, address_q, bdt_base_low_page_q, host_token_command_q;
    logic [7:0] frame_stop_threshold_q, bdt_base_mid_page_q, bdt_base_high_page_q;
    logic [7:0] endpoint_zero_control_q;
    logic busy_q, busy_d, ack_q, launch_q, launch_d;
    logic [31:0] rdat_q;
    logic [3:0] pid_q, ep_q;
    logic [6:0] taddr_q;
    logic ls_q, pre_q, hshk_q, rdis_q;
    uhtss_pkg::uhtss_state_t state_q, state_d;

    // Bus decode
    logic req, wr, wr_lane;
    logic hit_ctl, hit_adr, hit_low, hit_tok, hit_thr, hit_mid, hit_high, hit_ep0;
    logic [7:0] rd_byte;

    assign req = wb_cyc_in && wb_stb_in && !ack_q;
    assign wr = req && wb_we_in;
    assign wr_lane = wr && wb_sel_in[0];
    assign hit_ctl = reg_hit(wb_adr_in, uhtss_pkg::OFF_CONTROL);
    assign hit_adr = reg_hit(wb_adr_in, uhtss_pkg::OFF_ADDRESS);
    assign hit_low = reg_hit(wb_adr_in, uhtss_pkg::OFF_BDT_LOW);
    assign hit_tok = reg_hit(wb_adr_in, uhtss_pkg::OFF_TOKEN);
    assign hit_thr = reg_hit(wb_adr_in, uhtss_pkg::OFF_THRESHOLD);
    assign hit_mid = reg_hit(wb_adr_in, uhtss_pkg::OFF_BDT_MID);
    assign hit_high = reg_hit(wb_adr_in, uhtss_pkg::OFF_BDT_HIGH);
    assign hit_ep0 = reg_hit(wb_adr_in, uhtss_pkg::OFF_EP0);

    // Status bits
    logic host_en, usb_en, frame_blocked, frame_sof;

    assign host_en = control_q[uhtss_pkg::CTL_HOST_EN];
    assign usb_en = control_q[uhtss_pkg::CTL_USB_EN];

    // Read mux, unmapped reads zero
    logic [7:0] ctl_view;
    always_comb begin
        ctl_view = control_q;
        ctl_view[uhtss_pkg::CTL_TOKEN_BUSY] = busy_q;
    end

    assign rd_byte = hit_ctl ? ctl_view :
                     hit_adr ? address_q :
                     hit_low ? bdt_base_low_page_q :
                     hit_tok ? host_token_command_q :
                     hit_thr ? frame_stop_threshold_q :
                     hit_mid ? bdt_base_mid_page_q :
                     hit_high ? bdt_base_high_page_q :
                     hit_ep0 ? endpoint_zero_control_q : 8'h00;

    // Token write acceptance
    logic tok_write;
    logic tok_accept;
    assign tok_write = wr_lane && hit_tok;
    // Busy or disabled writes and invalid codes are dropped
    assign tok_accept = tok_write && host_en && !busy_q
                        && pid_valid(wb_dat_in[3:0]);

    always_ff @(posedge clock_in or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= req;
            rdat_q <= req ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    always_ff @(posedge clock_in or negedge nrst) begin
        if (!nrst) begin
            control_q <= uhtss_pkg::REG_RESET;
            address_q <= uhtss_pkg::REG_RESET;
            bdt_base_low_page_q <= uhtss_pkg::REG_RESET;
            frame_stop_threshold_q <= uhtss_pkg::REG_RESET;
            bdt_base_mid_page_q <= uhtss_pkg::REG_RESET;
            bdt_base_high_page_q <= uhtss_pkg::REG_RESET;
            endpoint_zero_control_q <= uhtss_pkg::REG_RESET;
        end else if (wr_lane) begin
            if (hit_ctl) begin
                control_q <= wb_dat_in[7:0] & uhtss_pkg::CTL_WR_MASK;
            end
            if (hit_adr) begin
                address_q <= wb_dat_in[7:0];
            end
            if (hit_low) begin
                bdt_base_low_page_q <= wb_dat_in[7:0] & uhtss_pkg::BDT_LOW_WR_MASK;
            end
            if (hit_thr) begin
                frame_stop_threshold_q <= wb_dat_in[7:0];
            end
            if (hit_mid) begin
                bdt_base_mid_page_q <= wb_dat_in[7:0];
            end
            if (hit_high) begin
                bdt_base_high_page_q <= wb_dat_in[7:0];
            end
            if (hit_ep0) begin
                endpoint_zero_control_q <= wb_dat_in[7:0] & uhtss_pkg::EP0_WR_MASK;
            end
        end
    end

    always_ff @(posedge clock_in or negedge nrst) begin
        if (!nrst) begin
            host_token_command_q <= uhtss_pkg::REG_RESET;
        end else if (tok_accept) begin
            host_token_command_q <= wb_dat_in[7:0];
        end
    end

    // Frame timing, runs in host operation with the module enabled
    uhtss_frame_timer u_frame (
        .clock_in(clock_in),
        .nrst_in(nrst),
        .run_in(host_en && usb_en),
        .thld_bytes_in(frame_stop_threshold_q),
        .sof_out(frame_sof),
        .blocked_out(frame_blocked),
        .count_out()
    );

    // Transaction sequencer
    logic retry;
    assign retry = link_nak_in && endpoint_zero_control_q[uhtss_pkg::EP0_HSHK]
                   && !endpoint_zero_control_q[uhtss_pkg::EP0_RETRY_DIS];

    always_comb begin
        state_d = state_q;
        launch_d = 1'b0;
        busy_d = busy_q;
        unique case (state_q)
            uhtss_pkg::ST_IDLE: begin
                if (tok_accept) begin
                    state_d = uhtss_pkg::ST_WAIT;
                    busy_d = 1'b1;
                end
            end
            uhtss_pkg::ST_WAIT: begin
                if (!host_en) begin
                    state_d = uhtss_pkg::ST_IDLE;
                    busy_d = 1'b0;
                end else if (!frame_blocked && !frame_sof) begin
                    state_d = uhtss_pkg::ST_RUN;
                    launch_d = 1'b1;
                end
            end
            uhtss_pkg::ST_RUN: begin
                if (link_done_in && retry && host_en) begin
                    state_d = uhtss_pkg::ST_WAIT;
                end else if (link_done_in) begin
                    state_d = uhtss_pkg::ST_IDLE;
                    busy_d = 1'b0;
                end
            end
            default: begin
                state_d = uhtss_pkg::ST_IDLE;
                busy_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge nrst) begin
        if (!nrst) begin
            state_q <= uhtss_pkg::ST_IDLE;
            busy_q <= 1'b0;
            launch_q <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q <= busy_d;
            launch_q <= launch_d;
        end
    end

    // Launch data captured from live registers at launch
    always_ff @(posedge clock_in or negedge nrst) begin
        if (!nrst) begin
            pid_q <= 4'h0;
            ep_q <= 4'h0;
            taddr_q <= 7'h00;
            ls_q <= 1'b0;
            pre_q <= 1'b0;
            hshk_q <= 1'b0;
            rdis_q <= 1'b0;
        end else if (launch_d) begin
            pid_q <= host_token_command_q[3:0];
            ep_q <= host_token_command_q[7:4];
            taddr_q <= address_q[6:0];
            ls_q <= address_q[uhtss_pkg::ADR_LOW_SPEED];
            pre_q <= address_q[uhtss_pkg::ADR_LOW_SPEED]
                     && !endpoint_zero_control_q[uhtss_pkg::EP0_WO_HUB];
            hshk_q <= endpoint_zero_control_q[uhtss_pkg::EP0_HSHK];
            rdis_q <= endpoint_zero_control_q[uhtss_pkg::EP0_RETRY_DIS];
        end
    end

    // Outputs
    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdat_q;
    assign tok_launch_out = launch_q;
    assign tok_pid_out = pid_q;
    assign tok_endpoint_out = ep_q;
    assign tok_addr_out = taddr_q;
    assign tok_low_speed_out = ls_q;
    assign tok_preamble_out = pre_q;
    assign tok_handshake_out = hshk_q;
    assign tok_retry_dis_out = rdis_q;
    assign sof_send_out = frame_sof;
    assign descriptor_base_out = {bdt_base_high_page_q, bdt_base_mid_page_q,
        bdt_base_low_page_q[7:1], {uhtss_pkg::BDT_ALIGN_BITS{1'b0}}};

    AST_LAUNCH_HOST: assert property (@(posedge clock_in) disable iff (!nrst)
        tok_launch_out |-> $past(host_en))
        else $error("token launched without host operation");
    AST_LAUNCH_ADDR: assert property (@(posedge clock_in) disable iff (!nrst)
        launch_d |=> tok_launch_out && tok_addr_out == $past(address_q[6:0]))
        else $error("launched token carries wrong address");
    AST_LAUNCH_GATED: assert property (@(posedge clock_in) disable iff (!nrst)
        tok_launch_out |-> !$past(frame_blocked) && !$past(frame_sof))
        else $error("token launched inside frame stop window");
    AST_PID_VALID: assert property (@(posedge clock_in) disable iff (!nrst)
        tok_launch_out |-> pid_valid(tok_pid_out) && tok_endpoint_out == host_token_command_q[7:4])
        else $error("invalid token type or endpoint launched");
    AST_BUSY_SET: assert property (@(posedge clock_in) disable iff (!nrst)
        tok_accept |=> busy_q ##1 (busy_q || !host_en))
        else $error("busy flag not set after token write");

    AST_BUSY_DONE: assert property (@(posedge clock_in) disable iff (!nrst)
        state_q == uhtss_pkg::ST_RUN && link_done_in && !retry |=> !busy_q)
        else $error("busy flag not cleared after transaction");

    AST_RETRY_NAK: assert property (@(posedge clock_in) disable iff (!nrst)
        state_q == uhtss_pkg::ST_RUN && link_done_in && retry && host_en
        |=> busy_q && state_q == uhtss_pkg::ST_WAIT)
        else $error("NAKed transaction not retried");

    AST_PREAMBLE: assert property (@(posedge clock_in) disable iff (!nrst)
        tok_launch_out |-> tok_preamble_out == (tok_low_speed_out
            && !$past(endpoint_zero_control_q[uhtss_pkg::EP0_WO_HUB])))
        else $error("preamble does not follow low-speed setting");

    AST_BASE_ALIGN: assert property (@(posedge clock_in) disable iff (!nrst)
        descriptor_base_out[8:0] == 9'h000
        && descriptor_base_out[31:24] == bdt_base_high_page_q)
        else $error("descriptor base misaligned or wrong high bits");

    AST_ACK_ONE: assert property (@(posedge clock_in) disable iff (!nrst)
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
        else $error("bus ack not a single cycle after request");

endmodule : uhtss_top

// >>> shared/uhtss_pkg.sv
/*
 * Constants for the host token launcher and frame scheduler: register
 * offsets, field positions, reset values, token codes and frame timing.
 * Assumes a 50 MHz module clock and a full-speed link at 12 Mbit/s.
 */
package uhtss_pkg;

    // Clock and link rates
    localparam int CLK_HZ = 50_000_000;
    localparam int BIT_HZ = 12_000_000;
    // Bit-time tick: add STEP each clock, wrap at MOD
    localparam logic [5:0] TICK_STEP = 6'(BIT_HZ / 1_000_000);
    localparam logic [5:0] TICK_MOD = 6'(CLK_HZ / 1_000_000);

    // Frame interval in microseconds and its reload in bit times
    localparam int FRAME_US = 1000;
    localparam logic [13:0] SOF_RELOAD = 14'(BIT_HZ / 1_000_000 * FRAME_US);
    localparam int BITS_PER_BYTE_LOG2 = 3;

    // Register byte offsets
    localparam logic [23:0] OFF_CONTROL = 24'h1c0094;
    localparam logic [23:0] OFF_ADDRESS = 24'h1c0098;
    localparam logic [23:0] OFF_BDT_LOW = 24'h1c009c;
    localparam logic [23:0] OFF_TOKEN = 24'h1c00a8;
    localparam logic [23:0] OFF_THRESHOLD = 24'h1c00ac;
    localparam logic [23:0] OFF_BDT_MID = 24'h1c00b0;
    localparam logic [23:0] OFF_BDT_HIGH = 24'h1c00b4;
    localparam logic [23:0] OFF_EP0 = 24'h1c00c0;

    // Control register fields
    localparam int CTL_USB_EN = 0;
    localparam int CTL_HOST_EN = 3;
    localparam int CTL_TOKEN_BUSY = 5;
    localparam logic [7:0] CTL_WR_MASK = 8'h09;

    // Address register fields
    localparam int ADR_LOW_SPEED = 7;

    // Endpoint zero control fields
    localparam int EP0_HSHK = 0;
    localparam int EP0_RETRY_DIS = 6;
    localparam int EP0_WO_HUB = 7;
    localparam logic [7:0] EP0_WR_MASK = 8'hdf;

    // Low page bit 0 always reads zero
    localparam logic [7:0] BDT_LOW_WR_MASK = 8'hfe;
    localparam int BDT_ALIGN_BITS = 9;

    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [13:0] CNT_RESET = 14'h0000;

    // Token types
    localparam logic [3:0] PID_OUT = 4'h1;
    localparam logic [3:0] PID_IN = 4'h9;
    localparam logic [3:0] PID_SETUP = 4'hd;

    // Transaction sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b11
    } uhtss_state_t;

endpackage : uhtss_pkg

// >>> logic/uhtss_frame_timer.sv
/*
 * Frame interval timer: counts bit times down from the reload value,
 * pulses at the end of each frame and closes the token gate near it.
 * Assumes an active-low reset already synchronised to the clock.
 */
module uhtss_frame_timer (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Control
    input wire logic run_in,
    input wire logic [7:0] thld_bytes_in,
    // Status
    output logic sof_out,
    output logic blocked_out,
    output logic [13:0] count_out
);

    logic [5:0] acc_q;
    logic [5:0] acc_d;
    logic [13:0] cnt_q;
    logic [13:0] cnt_d;
    logic run_q;
    logic sof_q;
    logic sof_d;
    logic blk_q;
    logic blk_d;
    logic [6:0] acc_sum;
    logic tick;
    logic [13:0] thld_bits;
    logic hit;

    // Bit-time tick from the module clock
    assign acc_sum = {1'b0, acc_q} + {1'b0, uhtss_pkg::TICK_STEP};
    assign tick = acc_sum >= {1'b0, uhtss_pkg::TICK_MOD};
    assign acc_d = tick ? 6'(acc_sum - {1'b0, uhtss_pkg::TICK_MOD}) : acc_sum[5:0];

    // Threshold in bit times
    assign thld_bits = {3'b000, thld_bytes_in, 3'b000};
    assign hit = run_q && (cnt_q <= thld_bits);

    always_comb begin
        cnt_d = cnt_q;
        sof_d = 1'b0;
        if (!run_in) begin
            cnt_d = uhtss_pkg::CNT_RESET;
        end else if (!run_q) begin
            cnt_d = uhtss_pkg::SOF_RELOAD;
        end else if (tick && cnt_q <= 14'h0001) begin
            sof_d = 1'b1;
            cnt_d = uhtss_pkg::SOF_RELOAD;
        end else if (tick) begin
            cnt_d = cnt_q - 14'h0001;
        end
    end

    // Gate stays closed from the threshold until the frame pulse
    assign blk_d = run_in && !sof_d && (blk_q || hit);

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc_q <= 6'h00;
            cnt_q <= uhtss_pkg::CNT_RESET;
            run_q <= 1'b0;
            sof_q <= 1'b0;
            blk_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            run_q <= run_in;
            sof_q <= sof_d;
            blk_q <= blk_d;
        end
    end

    assign sof_out = sof_q;
    assign blocked_out = blk_q;
    assign count_out = cnt_q;

    AST_SOF_RELOAD: assert property (@(posedge clock_in) disable iff (!nrst_in)
        sof_q && run_in |-> cnt_q == 14'h2ee0)
        else $error("frame counter not reloaded at frame pulse");

    AST_GATE_REOPEN: assert property (@(posedge clock_in) disable iff (!nrst_in)
        sof_q && run_in && thld_bytes_in < 8'hc8 |=> !blk_q)
        else $error("token gate still closed after frame pulse");

endmodule : uhtss_frame_timer

// >>> tb/uhtss_link_model.sv
/*
 * Serial engine and peripheral model: answers each launch with a done pulse.
 * Assumes the launcher's clock; NAKs only while the bench asks for it.
 */
module uhtss_link_model (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Launch from the block
    input wire logic launch_in,
    // Bench commands
    input wire logic slow_in,
    input wire logic nak_in,
    // Answer
    output logic done_out,
    output logic nak_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_q;
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wait_q <= 0;
            done_out <= 1'b0;
            nak_out <= 1'b0;
        end else begin
            done_out <= (wait_q == 1);
            nak_out <= (wait_q == 1) && nak_in;
            if (launch_in) begin
                wait_q <= slow_in ? 40 : 4;
            end else if (wait_q != 0) begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule : uhtss_link_model

// >>> tb/uhtss_top_tb.sv
/*
 * Self-checking bench: Wishbone register tasks, token launches, NAK retry,
 * frame timing and the threshold gate.
 * Assumes the link model answers launches on the same clock.
 */
module uhtss_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = '0;
    logic [31:0] dat = '0;
    logic [3:0] sel = '0;
    logic slow = 1'b0;
    logic nakq = 1'b0;
    logic [31:0] rdat, base, r;
    logic ack, done, nak, launch, ls, pre, hs, rdis, sof;
    logic [3:0] pid, ep;
    logic [6:0] ta;
    logic [18:0] lf;
    logic [3:0] pids [3] = '{4'h1, 4'h9, 4'hd};
    int miscompares = 0;
    int n_tests = 0;
    int cyc_n = 0;
    int n_launch = 0;
    int n_sof = 0;
    int t_sof = 0;
    int t_launch = 0;
    int t_en, s0, l0, k;

    always #10 clk = ~clk;

    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (launch === 1'b1) begin
            n_launch <= n_launch + 1;
            t_launch <= cyc_n;
            lf <= {pid, ep, ta, ls, pre, hs, rdis};
        end
        if (sof === 1'b1) begin
            n_sof <= n_sof + 1;
            t_sof <= cyc_n;
        end
    end

    uhtss_top i_uhtss_top (.clock_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .tok_launch_out(launch), .tok_pid_out(pid), .tok_endpoint_out(ep),
        .tok_addr_out(ta), .tok_low_speed_out(ls), .tok_preamble_out(pre),
        .tok_handshake_out(hs), .tok_retry_dis_out(rdis), .link_done_in(done),
        .link_nak_in(nak), .sof_send_out(sof), .descriptor_base_out(base));

    uhtss_link_model i_uhtss_link_model (.clock_in(clk), .nrst_in(nrst),
        .launch_in(launch), .slow_in(slow), .nak_in(nakq), .done_out(done),
        .nak_out(nak));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk

    task automatic wb(input logic w, input logic [23:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {8'h00, a};
        dat <= {24'h000000, d};
        sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        chk("wishbone ack", 32'h1, {31'h0, ack});
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rd(input logic [23:0] a, input logic [7:0] e, input string nm);
        wb(1'b0, a, 8'h00);
        chk(nm, {24'h000000, e}, r);
    endtask : rd

    task automatic wait_l(input int n);
        int m;
        m = 0;
        while (n_launch < n && m < 300) begin
            @(posedge clk);
            m++;
        end
        chk("launch count", n, n_launch);
    endtask : wait_l

    task automatic wait_nak();
        int m;
        m = 0;
        while (nak !== 1'b1 && m < 100) begin
            @(posedge clk);
            m++;
        end
        chk("nak answer", 32'h1, {31'h0, nak});
    endtask : wait_nak

    task automatic stop_test();
        $display("Counts: %0d comparisons, %0d mismatches", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (70000) @(posedge clk);
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(24'h1c00b0, 8'h00, "mid page reset");
        rd(24'h1c00b4, 8'h00, "high page reset");
        wb(1'b1, 24'h1c00b0, 8'ha5);
        wb(1'b1, 24'h1c00b4, 8'h3c);
        wb(1'b1, 24'h1c009c, 8'hff);
        rd(24'h1c009c, 8'hfe, "low page");
        rd(24'h1c00b0, 8'ha5, "mid page");
        rd(24'h1c00b4, 8'h3c, "high page");
        chk("descriptor base", {8'h3c, 8'ha5, 7'h7f, 9'h000}, base);
        rd(24'h1c00bc, 8'h00, "unmapped");
        $display("Test pages done");
        wb(1'b1, 24'h1c0094, 8'h01);
        wb(1'b1, 24'h1c00a8, 8'h31);
        repeat (10) @(posedge clk);
        chk("launch with host off", 0, n_launch);
        rd(24'h1c00a8, 8'h00, "token ignored");
        $display("Test host off done");
        slow <= 1'b1;
        wb(1'b1, 24'h1c0098, 8'h85);
        wb(1'b1, 24'h1c00c0, 8'h01);
        wb(1'b1, 24'h1c0094, 8'h09);
        foreach (pids[i]) begin
            l0 = n_launch;
            rd(24'h1c0094, 8'h09, "busy clear");
            wb(1'b1, 24'h1c00a8, {4'h3, pids[i]});
            wait_l(l0 + 1);
            chk("fields", {13'h0, pids[i], 4'h3, 7'h05, 4'he}, {13'h0, lf});
            rd(24'h1c0094, 8'h29, "busy set");
            repeat (45) @(posedge clk);
            rd(24'h1c0094, 8'h09, "busy cleared");
        end
        l0 = n_launch;
        wb(1'b1, 24'h1c00a8, 8'h32);
        repeat (10) @(posedge clk);
        chk("invalid code", l0, n_launch);
        $display("Test token types done");
        slow <= 1'b0;
        wb(1'b1, 24'h1c0098, 8'hff);
        wb(1'b1, 24'h1c00c0, 8'h81);
        nakq <= 1'b1;
        wb(1'b1, 24'h1c00a8, 8'hf9);
        wait_nak();
        nakq <= 1'b0;
        wait_l(l0 + 2);
        chk("retry fields", {13'h0, 4'h9, 4'hf, 7'h7f, 4'ha}, {13'h0, lf});
        repeat (15) @(posedge clk);
        rd(24'h1c0094, 8'h09, "busy after retry");
        wb(1'b1, 24'h1c00c0, 8'hc1);
        nakq <= 1'b1;
        wb(1'b1, 24'h1c00a8, 8'hf9);
        wait_nak();
        nakq <= 1'b0;
        repeat (15) @(posedge clk);
        chk("no retry", l0 + 3, n_launch);
        chk("no retry bit", 32'hb, {28'h0, lf[3:0]});
        rd(24'h1c0094, 8'h09, "busy after nak");
        $display("Test nak done");
        wb(1'b1, 24'h1c0094, 8'h00);
        wb(1'b1, 24'h1c00ac, 8'h4a);
        rd(24'h1c00ac, 8'h4a, "threshold");
        wb(1'b1, 24'h1c0094, 8'h09);
        t_en = cyc_n;
        s0 = n_sof;
        l0 = n_launch;
        repeat (49000) @(posedge clk);
        chk("early frame", s0, n_sof);
        wb(1'b1, 24'h1c00a8, 8'h19);
        k = 0;
        while (n_sof == s0 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        chk("gate closed", l0, n_launch);
        chk("frame time", 32'h1, {31'h0, (t_sof - t_en >= 49990 && t_sof - t_en <= 50010)});
        wait_l(l0 + 1);
        chk("launch after frame", 32'h1, {31'h0, (t_launch > t_sof)});
        $display("Test frame done");
        stop_test();
    end
endmodule : uhtss_top_tb
